// [ces_status.sv]
// CAN error status and fault confinement reporting with an APB register slave
// assumes event pulses and the activity code come from logic on pclk
//
// Behaviour
// - three-bit last error kind in protocol_status bits 2:0
// - error-free transfer clears last error kind to code 0
// - reading protocol_status sets last error kind to all ones
// - stuffing fault is recorded as code 1
// - format fault is recorded as code 2
// - missing acknowledgement is recorded as code 3
// - recessive sent but dominant seen is recorded as code 4
// - dominant sent but recessive seen is recorded as code 5
// - each 11 recessive bits in bus-off recovery writes code 5
// - checksum mismatch is recorded as code 6
// - two-bit bus activity: sync, idle, receiver, transmitter
// - bit 5 high while error passive, low while error active
// - warning bit set once either counter reaches 96
// - bit 7 high while bus-off, low otherwise
// - transmit counter in bits 7:0, maximum 255
// - receive counter in bits 14:8, shown at most 127
// - bit 15 set once receive count reaches 128
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module ces_status #(
  parameter int WARN_LIMIT    = 96,
  parameter int PASSIVE_LEVEL = 128,
  parameter int RECOVERY_RUNS = 128
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire ces_pkg::ces_evt_t evt,
  input  wire logic [1:0]       activity,
  output ces_pkg::ces_conf_t    conf,
  output logic                  irq
);

  // ==========================================================================
  // elaboration checks
  initial
  begin
    if (WARN_LIMIT < 1 || WARN_LIMIT > 255)
      $error("warning limit must fit the 8-bit tallies");
    if (PASSIVE_LEVEL <= WARN_LIMIT || PASSIVE_LEVEL > 255)
      $error("passive level must lie above the warning limit");
    if (RECOVERY_RUNS < 1 || RECOVERY_RUNS > 255)
      $error("recovery runs must fit the 8-bit run counter");
  end

  localparam logic [7:0] WARN_L = 8'(WARN_LIMIT);
  localparam logic [7:0] PASS_L = 8'(PASSIVE_LEVEL);
  localparam logic [7:0] RUNS_L = 8'(RECOVERY_RUNS - 1);

  typedef enum logic [1:0] {ST_ACTIVE, ST_PASSIVE, ST_BUS_OFF} ces_fc_state_t;

  // ==========================================================================
  // helpers
  function automatic logic [7:0] sat_add(input logic [7:0] v, input logic [7:0] inc);
    logic [8:0] s;
    s = {1'b0, v} + {1'b0, inc};
    sat_add = s[8] ? ces_pkg::TALLY_MAX : s[7:0];
  endfunction

  function automatic logic is_error_kind(input logic [2:0] k);
    unique case (k)
      ces_pkg::LEC_STUFF: is_error_kind = 1'b1;
      ces_pkg::LEC_FORM:  is_error_kind = 1'b1;
      ces_pkg::LEC_ACK:   is_error_kind = 1'b1;
      ces_pkg::LEC_BIT1:  is_error_kind = 1'b1;
      ces_pkg::LEC_BIT0:  is_error_kind = 1'b1;
      ces_pkg::LEC_CRC:   is_error_kind = 1'b1;
      default:            is_error_kind = 1'b0;
    endcase
  endfunction

  function automatic logic at_or_above(input logic [7:0] a, input logic [7:0] b, input logic [7:0] lim);
    at_or_above = (a >= lim) || (b >= lim);
  endfunction

  // ==========================================================================
  // state
  logic [7:0]    tec_q;
  logic [7:0]    tec_d;
  logic [7:0]    rec_q;
  logic [7:0]    rec_d;
  logic [7:0]    runs_q;
  logic [7:0]    runs_d;
  ces_fc_state_t fc_q;
  ces_fc_state_t fc_d;
  logic [2:0]    lec_q;
  logic [1:0]    act_q;
  logic [ces_pkg::IRQ_W-1:0] irq_stat_q;
  logic [ces_pkg::IRQ_W-1:0] irq_mask_q;
  logic [ces_pkg::IRQ_W-1:0] irq_set;
  logic [ces_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0]   prdata_q;
  logic          pslverr_q;

  logic          err_hit;
  logic          recov_step;
  logic          rd_setup;
  logic          wr_access;
  logic          mapped;
  logic          ep_now;
  logic          warn_now;
  logic          bus_off_flag_now;
  logic [31:0]   ps_word;
  logic [31:0]   fc_word;
  logic [31:0]   rd_mux;

  assign err_hit    = evt.err_valid && is_error_kind(evt.err_kind) && (fc_q != ST_BUS_OFF);
  assign recov_step = (fc_q == ST_BUS_OFF) && evt.recessive11;

  // ==========================================================================
  // fault confinement tallies
  // bus-off is entered when a transmit step would pass 255, so the tally
  // saturates there instead of wrapping
  always_comb
  begin
    tec_d  = tec_q;
    rec_d  = rec_q;
    runs_d = runs_q;
    fc_d   = fc_q;
    if (fc_q == ST_BUS_OFF)
    begin
      if (evt.recessive11)
      begin
        if (runs_q == RUNS_L)
        begin
          tec_d  = 8'h00;
          rec_d  = 8'h00;
          runs_d = 8'h00;
          fc_d   = ST_ACTIVE;
        end
        else
          runs_d = runs_q + 8'h01;
      end
    end
    else
    begin
      if (err_hit && evt.err_as_tx)
      begin
        if (tec_q > (ces_pkg::TALLY_MAX - ces_pkg::TEC_STEP))
        begin
          tec_d = ces_pkg::TALLY_MAX;
          fc_d  = ST_BUS_OFF;
        end
        else
          tec_d = sat_add(tec_q, ces_pkg::TEC_STEP);
      end
      else if (err_hit)
        rec_d = sat_add(rec_q, 8'h01);
      else
      begin
        if (evt.ok_tx && tec_q != 8'h00)
          tec_d = tec_q - 8'h01;
        if (evt.ok_rx)
        begin
          if (rec_q > ces_pkg::REC_SHOWN_MAX)
            rec_d = ces_pkg::REC_REWIND;
          else if (rec_q != 8'h00)
            rec_d = rec_q - 8'h01;
        end
      end
      if (fc_d != ST_BUS_OFF)
        fc_d = at_or_above(tec_d, rec_d, PASS_L) ? ST_PASSIVE : ST_ACTIVE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tec_q  <= 8'h00;
      rec_q  <= 8'h00;
      runs_q <= 8'h00;
      fc_q   <= ST_ACTIVE;
    end
    else
    begin
      tec_q  <= tec_d;
      rec_q  <= rec_d;
      runs_q <= runs_d;
      fc_q   <= fc_d;
    end
  end

  assign ep_now   = (fc_q == ST_PASSIVE);
  assign bus_off_flag_now = (fc_q == ST_BUS_OFF);
  assign warn_now = at_or_above(tec_q, rec_q, WARN_L);
  assign conf     = '{error_passive: ep_now, bus_off: bus_off_flag_now};

  // ==========================================================================
  // last error kind and activity
  // an event in the same cycle as a status read wins over the read's all-ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lec_q <= ces_pkg::LEC_RESET;
    else if (err_hit)
      lec_q <= evt.err_kind;
    else if (recov_step)
      lec_q <= ces_pkg::LEC_BIT0;
    else if (evt.ok_tx || evt.ok_rx)
      lec_q <= ces_pkg::LEC_NONE;
    else if (rd_setup && paddr == ces_pkg::PROTO_STATUS_OFS)
      lec_q <= ces_pkg::LEC_NO_EVT;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_q <= ces_pkg::ACT_SYNC;
    else
      act_q <= activity;
  end

  // ==========================================================================
  // status words, reserved bits tied low
  always_comb
  begin
    ps_word = 32'h0000_0000;
    ps_word[ces_pkg::LEC_MSB:ces_pkg::LEC_LSB] = lec_q;
    ps_word[ces_pkg::ACT_MSB:ces_pkg::ACT_LSB] = act_q;
    ps_word[ces_pkg::EP_BIT]   = ep_now;
    ps_word[ces_pkg::WARN_BIT] = warn_now;
    ps_word[ces_pkg::BUS_OFF_FLAG_BIT] = bus_off_flag_now;
  end

  always_comb
  begin
    fc_word = 32'h0000_0000;
    fc_word[ces_pkg::TEC_MSB:ces_pkg::TEC_LSB] = tec_q;
    fc_word[ces_pkg::REC_MSB:ces_pkg::REC_LSB] =
      (rec_q > ces_pkg::REC_SHOWN_MAX) ? ces_pkg::REC_SHOWN_MAX[6:0] : rec_q[6:0];
    fc_word[ces_pkg::RP_BIT] = (rec_q >= PASS_L);
  end

  // ==========================================================================
  // interrupts: sticky status, write one to clear, set beats clear
  assign irq_set[ces_pkg::IRQ_ERR]   = err_hit;
  assign irq_set[ces_pkg::IRQ_EP]    = (fc_d == ST_PASSIVE) != ep_now;
  assign irq_set[ces_pkg::IRQ_WARN]  = at_or_above(tec_d, rec_d, WARN_L) != warn_now;
  assign irq_set[ces_pkg::IRQ_BUS_OFF_FLAG]  = (fc_d == ST_BUS_OFF) != bus_off_flag_now;
  assign irq_set[ces_pkg::IRQ_RECOV] = recov_step;
  assign irq_clr = (wr_access && paddr == ces_pkg::IRQ_STATUS_OFS) ? pwdata[ces_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= ces_pkg::IRQ_MASK_RESET;
    else if (wr_access && paddr == ces_pkg::IRQ_MASK_OFS)
      irq_mask_q <= pwdata[ces_pkg::IRQ_W-1:0];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================================
  // apb slave: read data is captured in the setup cycle so the access phase
  // always completes with no wait state; writes land at the access edge
  assign rd_setup  = psel && !penable && !pwrite;
  assign wr_access = psel && penable && pwrite && !pslverr_q;
  assign mapped    = (paddr == ces_pkg::PROTO_STATUS_OFS) || (paddr == ces_pkg::FAULT_COUNTERS_OFS) ||
                     (paddr == ces_pkg::IRQ_STATUS_OFS)   || (paddr == ces_pkg::IRQ_MASK_OFS);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ces_pkg::PROTO_STATUS_OFS:   rd_mux = ps_word;
      ces_pkg::FAULT_COUNTERS_OFS: rd_mux = fc_word;
      ces_pkg::IRQ_STATUS_OFS:     rd_mux[ces_pkg::IRQ_W-1:0] = irq_stat_q;
      ces_pkg::IRQ_MASK_OFS:       rd_mux[ces_pkg::IRQ_W-1:0] = irq_mask_q;
      default:                     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= !mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && pslverr_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tx_error;
    err_hit && evt.err_as_tx;
  endsequence

  sequence s_tx_fatal;
    s_tx_error ##0 (tec_q > (ces_pkg::TALLY_MAX - ces_pkg::TEC_STEP));
  endsequence

  sequence s_recov_last;
    recov_step && runs_q == RUNS_L;
  endsequence

  sequence s_status_read;
    rd_setup && paddr == ces_pkg::PROTO_STATUS_OFS;
  endsequence

  a_lec_error_code: assert property (err_hit |=> lec_q == $past(evt.err_kind))
    else $error("last error kind did not take the error code");

  a_lec_clean_clear: assert property ((evt.ok_tx || evt.ok_rx) && !err_hit && !recov_step
                                      |=> lec_q == ces_pkg::LEC_NONE)
    else $error("clean transfer did not clear last error kind");

  a_lec_read_ones: assert property (s_status_read ##0 (!err_hit && !recov_step && !evt.ok_tx && !evt.ok_rx)
                                    |=> lec_q == ces_pkg::LEC_NO_EVT ##1 prdata[2:0] == $past(lec_q, 2))
    else $error("status read did not leave all ones in last error kind");

  a_recov_bit0: assert property (recov_step |=> lec_q == ces_pkg::LEC_BIT0 && irq_stat_q[ces_pkg::IRQ_RECOV])
    else $error("recovery run did not report code five");

  a_recov_exit: assert property (s_recov_last |=> !bus_off_flag_now && tec_q == 8'h00 && rec_q == 8'h00)
    else $error("bus-off did not end after the last recovery run");

  a_busoff_entry: assert property (s_tx_fatal |=> bus_off_flag_now [*2])
    else $error("bus-off not entered on transmit overflow");

  a_tec_step: assert property (s_tx_error ##0 !(tec_q > (ces_pkg::TALLY_MAX - ces_pkg::TEC_STEP))
                               |=> tec_q == $past(tec_q) + ces_pkg::TEC_STEP)
    else $error("transmit tally did not rise by eight");

  a_activity_follow: assert property (##1 ps_word[ces_pkg::ACT_MSB:ces_pkg::ACT_LSB] == $past(activity))
    else $error("activity field lags its input");

  a_passive_flag: assert property (ps_word[ces_pkg::EP_BIT] ==
                                   (!bus_off_flag_now && at_or_above(tec_q, rec_q, PASS_L)))
    else $error("error passive bit disagrees with the tallies");

  a_warning_flag: assert property (ps_word[ces_pkg::WARN_BIT] == (tec_q >= 8'd96 || rec_q >= 8'd96)
                                   || WARN_LIMIT != 96)
    else $error("warning bit disagrees with the limit of 96");

  a_rec_shown_cap: assert property (fc_word[ces_pkg::REC_MSB:ces_pkg::REC_LSB] ==
                                    ((rec_q > 8'd127) ? 7'd127 : rec_q[6:0]))
    else $error("receive tally field not capped at 127");

  a_rp_flag: assert property ($rose(rec_q >= 8'd128) |-> fc_word[ces_pkg::RP_BIT]
                              || PASSIVE_LEVEL != 128)
    else $error("receive passive bit missing at 128");

  a_reserved_zero: assert property (rd_setup |=> prdata[31:16] == 16'h0000 &&
                                    ($past(paddr) != ces_pkg::PROTO_STATUS_OFS || prdata[15:8] == 8'h00))
    else $error("reserved bits read as nonzero");

  a_irq_level: assert property (irq == |(irq_stat_q & irq_mask_q))
    else $error("interrupt level disagrees with status and mask");

  // set beats a write-one-to-clear in the same cycle
  a_irq_sticky_set: assert property (irq_set[ces_pkg::IRQ_ERR] |=> irq_stat_q[ces_pkg::IRQ_ERR])
    else $error("error interrupt bit not set after an accepted error");

endmodule

// [ces_pkg.sv]
// constants, field layout and carrier types for the CAN error status block
// assumes the protocol engine runs on the same clock as the register bus
package ces_pkg;

  // ==========================================================================
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] PROTO_STATUS_OFS   = 8'h00;
  localparam logic [7:0] FAULT_COUNTERS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS     = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h0C;

  // ==========================================================================
  // protocol_status field positions
  localparam int LEC_LSB    = 0;
  localparam int LEC_MSB    = 2;
  localparam int ACT_LSB    = 3;
  localparam int ACT_MSB    = 4;
  localparam int EP_BIT     = 5;
  localparam int WARN_BIT   = 6;
  localparam int BUS_OFF_FLAG_BIT   = 7;

  // fault_counters field positions
  localparam int TEC_LSB    = 0;
  localparam int TEC_MSB    = 7;
  localparam int REC_LSB    = 8;
  localparam int REC_MSB    = 14;
  localparam int RP_BIT     = 15;

  // ==========================================================================
  // last error kind codes
  localparam logic [2:0] LEC_NONE    = 3'h0;
  localparam logic [2:0] LEC_STUFF   = 3'h1;
  localparam logic [2:0] LEC_FORM    = 3'h2;
  localparam logic [2:0] LEC_ACK     = 3'h3;
  localparam logic [2:0] LEC_BIT1    = 3'h4;
  localparam logic [2:0] LEC_BIT0    = 3'h5;
  localparam logic [2:0] LEC_CRC     = 3'h6;
  localparam logic [2:0] LEC_NO_EVT  = 3'h7;

  // bus activity codes
  localparam logic [1:0] ACT_SYNC    = 2'h0;
  localparam logic [1:0] ACT_IDLE    = 2'h1;
  localparam logic [1:0] ACT_RX      = 2'h2;
  localparam logic [1:0] ACT_TX      = 2'h3;

  // ==========================================================================
  // fault confinement figures and reset values
  localparam logic [7:0] TEC_STEP       = 8'h08;
  localparam logic [7:0] TALLY_MAX      = 8'hFF;
  localparam logic [7:0] REC_SHOWN_MAX  = 8'h7F;
  localparam logic [7:0] REC_REWIND     = 8'h78;
  localparam logic [2:0] LEC_RESET      = 3'h0;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
  localparam int         IRQ_W          = 5;

  // interrupt status bit positions
  localparam int IRQ_ERR   = 0;
  localparam int IRQ_EP    = 1;
  localparam int IRQ_WARN  = 2;
  localparam int IRQ_BUS_OFF_FLAG  = 3;
  localparam int IRQ_RECOV = 4;

  // ==========================================================================
  // events reported by the protocol engine, one-cycle pulses
  typedef struct packed {
    logic       err_valid;
    logic [2:0] err_kind;
    logic       err_as_tx;
    logic       ok_tx;
    logic       ok_rx;
    logic       recessive11;
  } ces_evt_t;

  // confinement state handed back to the protocol engine
  typedef struct packed {
    logic error_passive;
    logic bus_off;
  } ces_conf_t;

endpackage

// [ces_bus_model.sv]
// far-side model: turns bench requests into engine event pulses and activity
// assumes it shares pclk and presetn with the status block
module ces_bus_model (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire ces_pkg::ces_evt_t evt_req,
  input  wire logic [1:0]        act_req,
  output ces_pkg::ces_evt_t      evt,
  output logic [1:0]             activity
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // registered so every pulse lands one edge after the bench asks for it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt      <= '0;
      activity <= ces_pkg::ACT_SYNC;
    end
    else
    begin
      evt      <= evt_req;
      activity <= act_req;
    end
  end
endmodule

// [tb_top.sv]
// self-checking bench for the error status block over APB
// assumes zero-wait APB slave and event results visible one cycle after a pulse
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((e) !== (g)) \
    begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  ces_pkg::ces_evt_t evt_req = '0;
  ces_pkg::ces_evt_t evt;
  logic [1:0]        act_req = 2'h0;
  logic [1:0]        activity;
  ces_pkg::ces_conf_t conf;
  logic              irq;
  logic [32:0]       exp_q[$];
  logic [32:0]       note;
  logic [31:0]       seed = 32'he568_8ae9;
  int                errors = 0;
  int                num_checks = 0;
  int                cycles = 0;

  ces_bus_model u_bus (.pclk(pclk), .presetn(presetn), .evt_req(evt_req), .act_req(act_req),
                       .evt(evt), .activity(activity));

  ces_status #(.RECOVERY_RUNS(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .activity(activity), .conf(conf), .irq(irq));

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] st(input logic [2:0] l, input logic [1:0] a, input logic ep,
                                     input logic wn, input logic bo);
    return {24'h00_0000, bo, wn, ep, a, l};
  endfunction

  function automatic ces_pkg::ces_evt_t ev(input logic [2:0] k, input logic tx, input logic okr,
                                           input logic r11);
    return {(k != 3'h0), k, tx, 1'b0, okr, r11};
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // the note goes in before the transfer starts, the watcher pops it at the access edge
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
    exp_q.push_back({e, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic fire(input ces_pkg::ces_evt_t e);
    @(posedge pclk);
    evt_req <= e;
    @(posedge pclk);
    evt_req <= '0;
    repeat (2) @(posedge pclk);
  endtask

  // ==========================================================================
  // watcher and timeout
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
    if (presetn && psel && penable && pready && !pwrite)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("mismatch read_note expected entry seen none");
      end
      else
      begin
        note = exp_q.pop_front();
        `CHK("prdata", note[31:0], prdata)
        `CHK("pslverr", note[32], pslverr)
      end
    end
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    logic [7:0] transmit_fault_tally;
    logic [7:0] receive_fault_tally;
    logic [2:0] k;
    logic       bo;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, st(3'h0, 2'h0, 1'b0, 1'b0, 1'b0), 1'b0);
    rd(8'h00, st(3'h7, 2'h0, 1'b0, 1'b0, 1'b0), 1'b0);
    rd(8'h04, 32'h0000_0000, 1'b0);
    rd(8'h0C, 32'h0000_0000, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h00, rnd());
    apb(1'b1, 8'h04, rnd());
    for (int a = 0; a < 4; a++)
    begin
      act_req <= a[1:0];
      repeat (3) @(posedge pclk);
      rd(8'h00, st(3'h7, a[1:0], 1'b0, 1'b0, 1'b0), 1'b0);
    end
    for (int i = 1; i <= 6; i++)
    begin
      fire(ev(i[2:0], 1'b0, 1'b0, 1'b0));
      rd(8'h00, st(i[2:0], 2'h3, 1'b0, 1'b0, 1'b0), 1'b0);
      rd(8'h04, {16'h0000, i[7:0], 8'h00}, 1'b0);
    end
    fire(ev(3'h0, 1'b0, 1'b1, 1'b0));
    rd(8'h00, st(3'h0, 2'h3, 1'b0, 1'b0, 1'b0), 1'b0);
    // transmit faults walk the counter through warning, passive and off
    for (int i = 1; i <= 32; i++)
    begin
      fire(ev(3'h3, 1'b1, 1'b0, 1'b0));
      bo  = (i == 32);
      transmit_fault_tally = bo ? 8'hFF : 8'(i * 8);
      rd(8'h00, st(3'h3, 2'h3, !bo && transmit_fault_tally >= 8'h80, transmit_fault_tally >= 8'h60, bo), 1'b0);
      rd(8'h04, {16'h0000, 8'h05, transmit_fault_tally}, 1'b0);
      `CHK("conf", {!bo && transmit_fault_tally >= 8'h80, bo}, conf)
    end
    rd(8'h08, 32'h0000_000F, 1'b0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    rd(8'h0C, 32'h0000_001F, 1'b0);
    apb(1'b1, 8'h08, 32'h0000_000F);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    rd(8'h08, 32'h0000_0000, 1'b0);
    fire(ev(3'h0, 1'b0, 1'b0, 1'b1));
    rd(8'h00, st(3'h5, 2'h3, 1'b0, 1'b1, 1'b1), 1'b0);
    `CHK("irq recovery", 1'b1, irq)
    fire(ev(3'h0, 1'b0, 1'b0, 1'b1));
    rd(8'h00, st(3'h5, 2'h3, 1'b0, 1'b0, 1'b0), 1'b0);
    rd(8'h04, 32'h0000_0000, 1'b0);
    // receive faults of random kind up to the passive level of 128
    for (int i = 1; i <= 128; i++)
    begin
      k = 3'(1 + rnd() % 6);
      fire(ev(k, 1'b0, 1'b0, 1'b0));
      receive_fault_tally = (i >= 128) ? 8'hFF : 8'(i);
      rd(8'h04, {16'h0000, receive_fault_tally, 8'h00}, 1'b0);
      rd(8'h00, st(k, 2'h3, i >= 128, i >= 96, 1'b0), 1'b0);
    end
    repeat (4) @(posedge pclk);
    `CHK("notes left", 0, exp_q.size())
    stop_test();
  end
endmodule
